// file: serial_ctrl_regs.vh
// constants for the serial record output and total control block
// assumes ascii characters, one byte per symbol
`ifndef SERIAL_CTRL_REGS_VH
`define SERIAL_CTRL_REGS_VH
// characters recognised or sent
`define CH_T     8'h54
`define CH_L     8'h4C
`define CH_A     8'h41
`define CH_R     8'h52
`define CH_SL    8'h2F
`define CH_Y     8'h59
`define CH_SP    8'h20
`define CH_CR    8'h0D
`define CH_LF    8'h0A
`define CH_BS    8'h08
`define CH_DEL   8'h7F
`define CH_ESC   8'h1B
`define CH_0     8'h30
`define CH_9     8'h39
// interval setting
`define IVL_RST  14'h0000
`define DIG_MAX  3'h4
`define DIG_TEN  18'h0000A
// states
`define S_BAN    4'h0
`define S_IDLE   4'h1
`define S_SEND   4'h2
`define S_SLASH  4'h3
`define S_EDIT   4'h4
`define S_RWAIT  4'h5
`define S_RDEC   4'h6
`define S_WREC   4'h7
// message identifiers
`define M_BAN    4'h0
`define M_ECHO   4'h1
`define M_CHR    4'h2
`define M_NUM    4'h3
`define M_PRM    4'h4
`define M_RPR    4'h5
`define M_RDN    4'h6
`define M_ONOFF  4'h7
`define M_CRLF   4'h8
// message lengths in characters
`define L_BAN    6'h29
`define L_PRM    6'h06
`define L_RPR    6'h22
`define L_RDN    6'h18
`define L_ON     6'h13
`define L_OFF    6'h14
`define L_NUM    6'h06
// minutes in a day
`define DAY_MIN  12'h5A0
`endif

// file: serial_record_ctrl.v
// command interpreter for record output, interval and precipitation total
// assumes a uart on sys_clk with byte valid/ready, a one-second tick,
// an rtc and zone offset on sys_clk, and a record formatter that shares
// the transmit line and is only started while this block is silent
`timescale 1ns/1ps
`default_nettype none
`include "serial_ctrl_regs.vh"

// transmit fifo with a registered output stage
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             sys_clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] inData,
  input  wire             inValid,
  output wire             inReady,
  output reg  [WIDTH-1:0] outData,
  output reg              outValid,
  input  wire             outReady,
  output wire             busy
);
  localparam [AW:0] FULL = DEPTH[AW:0];
  reg [WIDTH-1:0] mem [0:DEPTH-1];  // storage words
  reg [AW-1:0]    wrPtr;            // next write slot
  reg [AW-1:0]    rdPtr;            // next read slot
  reg [AW:0]      count;            // words held in mem
  wire push = inValid && inReady;
  // refill the output stage whenever it is empty or being taken
  wire pop  = (count != {(AW+1){1'b0}}) && (!outValid || outReady);

  assign inReady = (count != FULL);
  // busy also covers the byte sitting in the output stage
  assign busy    = (count != {(AW+1){1'b0}}) || outValid;

  // memory write, no reset needed on data
  always @(posedge sys_clk) begin
    if (push)
      mem[wrPtr] <= inData;
  end

  // pointers, level and output stage
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr    <= {AW{1'b0}};
      rdPtr    <= {AW{1'b0}};
      count    <= {(AW+1){1'b0}};
      outData  <= {WIDTH{1'b0}};
      outValid <= 1'b0;
    end else begin
      if (push)
        wrPtr <= wrPtr + {{(AW-1){1'b0}}, 1'b1};
      if (pop) begin
        rdPtr    <= rdPtr + {{(AW-1){1'b0}}, 1'b1};
        outData  <= mem[rdPtr];
        outValid <= 1'b1;
      end else if (outReady) begin
        outValid <= 1'b0;
      end
      // level moves by push minus pop
      if (push && !pop)
        count <= count + {{AW{1'b0}}, 1'b1};
      else if (!push && pop)
        count <= count - {{AW{1'b0}}, 1'b1};
    end
  end
endmodule // byte_fifo

// Behaviour
// [RULE1] one record per host record request
// [RULE2] interval held in seconds, 0 to 9999
// [RULE3] nonzero interval streams records until stopped
// [RULE4] zero interval stops scheduled output
// [RULE5] interval one gives one record per second
// [RULE6] on-demand requests always answered
// [RULE7] four-line banner sent at power-up
// [RULE8] query and edit commands echoed plus space
// [RULE9] interval query prints four zero-padded digits
// [RULE10] query answers end carriage return, line feed
// [RULE11] interval edit prompts, takes four digits max
// [RULE12] backspace deletes, enter commits, escape discards
// [RULE13] enter with no digits stores zero
// [RULE14] running millimetre total kept until cleared
// [RULE15] clear command prompts, waits one character
// [RULE16] reply Y zeroes total and confirms
// [RULE17] any other reply leaves total unchanged
// [RULE18] auto clear zeroes total at local midnight
// [RULE19] auto clear query reports ON or OFF
// [RULE20] auto clear toggle inverts and reports state
// [RULE21] host should query after each edit
// [RULE22] local midnight uses signed zone offset
// [RULE23] committing an interval restarts the schedule
// [RULE24] records only go out between exchanges
module serial_record_ctrl (
  input  wire        sys_clk,
  input  wire        rst_n,
  input  wire [7:0]  rxData,
  input  wire        rxValid,
  output reg         rxReady,
  output wire [7:0]  txData,
  output wire        txValid,
  input  wire        txReady,
  input  wire        secTick,
  output reg         recordReq,
  input  wire        recordDone,
  input  wire [15:0] precipInc,
  input  wire        precipValid,
  input  wire [4:0]  rtcHour,
  input  wire [5:0]  rtcMin,
  input  wire        zoneNeg,
  input  wire [3:0]  zoneHour,
  input  wire [5:0]  zoneMin,
  output reg  [13:0] interval,
  output reg         autoClr,
  output reg  [31:0] total
);
  // fixed texts, octal escapes give carriage return and line feed
  localparam [8*41-1:0] BAN =
    "POWER ON\015\012RECORD OUT\015\012TOTAL CTRL\015\012READY\015\012";
  localparam [8*6-1:0]  PRM = "SSSS\015\012";
  localparam [8*34-1:0] RPR = "Reset precipitation total? (Y/N): ";
  localparam [8*24-1:0] RDN = "\015\012Total reset to zero.\015\012";
  localparam [8*19-1:0] TON = "Auto Reset is ON.\015\012";
  localparam [8*20-1:0] TOF = "Auto Reset is OFF.\015\012";

  reg [3:0]  state_reg, state_next;     // interpreter state
  reg [3:0]  msg_reg, msg_next;         // message being sent
  reg [3:0]  msg2_reg, msg2_next;       // message chained after it
  reg        has2_reg, has2_next;       // a chained message is waiting
  reg [3:0]  ret_reg, ret_next;         // state after the send
  reg [5:0]  idx_reg, idx_next;         // character index in message
  reg [7:0]  char_reg, char_next;       // last command character
  reg [13:0] ivl_next;                  // interval next value
  reg [13:0] editVal_reg, editVal_next; // digits typed so far
  reg [2:0]  editCnt_reg, editCnt_next; // number of digits typed
  reg        autoClr_next;              // auto clear enable next
  reg        tPend_reg;                 // host record request waiting
  reg        sPend_reg;                 // scheduled record waiting
  reg [13:0] secCnt_reg;                // seconds since the schedule last fell due
  reg        midPrev_reg;               // midnight seen last cycle
  reg        tSet, tServe, sServe;      // pending flag events
  reg        commit, cmdClr;            // interval store, total clear
  reg        recReq_next;               // record request pulse
  wire       fifoInReady;               // fifo has a free word
  wire       fifoBusy;                  // fifo still holds output
  wire [8:0] rom;                       // {last, character}
  wire       take = rxValid && rxReady; // character accepted
  reg [17:0] prod;                      // digit accumulate product

  // one character of message id at index i; bit 8 flags the last one
  function [8:0] msgChar;
    input [3:0]  id;
    input [5:0]  i;
    input [7:0]  c;
    input        onf;
    input [13:0] v;
    reg   [7:0]  ch;
    reg          lst;
    reg   [13:0] t;
    begin
      ch  = `CH_SP;
      lst = 1'b1;
      t   = 14'h0000;
      case (id)
        `M_BAN: begin
          ch  = BAN[8*(`L_BAN-6'h01-i) +: 8];
          lst = (i == `L_BAN - 6'h01);
        end
        `M_ECHO: begin
          // command character followed by a space
          ch  = (i == 6'h00) ? c : `CH_SP;
          lst = (i == 6'h01);
        end
        `M_CHR: ch = c;
        `M_NUM: begin
          // [RULE9] zero-padded four digits
          case (i[1:0])
            2'h0:    t = v / 14'd1000;
            2'h1:    t = (v / 14'd100) % 14'd10;
            2'h2:    t = (v / 14'd10) % 14'd10;
            default: t = v % 14'd10;
          endcase
          if (i < 6'h04)
            ch = `CH_0 + {4'h0, t[3:0]};
          else
            ch = (i == 6'h04) ? `CH_CR : `CH_LF;
          lst = (i == `L_NUM - 6'h01);
        end
        `M_PRM: begin
          ch  = PRM[8*(`L_PRM-6'h01-i) +: 8];
          lst = (i == `L_PRM - 6'h01);
        end
        `M_RPR: begin
          ch  = RPR[8*(`L_RPR-6'h01-i) +: 8];
          lst = (i == `L_RPR - 6'h01);
        end
        `M_RDN: begin
          ch  = RDN[8*(`L_RDN-6'h01-i) +: 8];
          lst = (i == `L_RDN - 6'h01);
        end
        `M_ONOFF: begin
          if (onf) begin
            ch  = TON[8*(`L_ON-6'h01-i) +: 8];
            lst = (i == `L_ON - 6'h01);
          end else begin
            ch  = TOF[8*(`L_OFF-6'h01-i) +: 8];
            lst = (i == `L_OFF - 6'h01);
          end
        end
        // [RULE10] carriage return, line feed
        `M_CRLF: begin
          ch  = (i == 6'h00) ? `CH_CR : `CH_LF;
          lst = (i == 6'h01);
        end
        default: ch = `CH_SP;
      endcase
      msgChar = {lst, ch};
    end
  endfunction

  // state that accepts a receive character
  function accepts;
    input [3:0] s;
    begin
      accepts = (s == `S_IDLE) || (s == `S_SLASH) ||
                (s == `S_EDIT) || (s == `S_RWAIT);
    end
  endfunction

  // begin a send of one message, optionally chained to a second
  task startSend;
    input [3:0] m;
    input [3:0] m2;
    input       h2;
    input [3:0] r;
    begin
      msg_next   = m;
      msg2_next  = m2;
      has2_next  = h2;
      ret_next   = r;
      idx_next   = 6'h00;
      state_next = `S_SEND;
    end
  endtask

  assign rom = msgChar(msg_reg, idx_reg, char_reg, autoClr, interval);

  // the transmit fifo decouples the rom walk from the uart pace
  byte_fifo #(
    .WIDTH (8),
    .DEPTH (16),
    .AW    (4)
  ) txFifo (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .inData   (rom[7:0]),
    .inValid  (state_reg == `S_SEND),
    .inReady  (fifoInReady),
    .outData  (txData),
    .outValid (txValid),
    .outReady (txReady),
    .busy     (fifoBusy)
  );

  // interpreter next-state logic
  always @* begin
    state_next   = state_reg;
    msg_next     = msg_reg;
    msg2_next    = msg2_reg;
    has2_next    = has2_reg;
    ret_next     = ret_reg;
    idx_next     = idx_reg;
    char_next    = char_reg;
    ivl_next     = interval;
    editVal_next = editVal_reg;
    editCnt_next = editCnt_reg;
    autoClr_next = autoClr;
    tSet         = 1'b0;
    tServe       = 1'b0;
    sServe       = 1'b0;
    commit       = 1'b0;
    cmdClr       = 1'b0;
    recReq_next  = 1'b0;
    prod         = editVal_reg * `DIG_TEN;
    case (state_reg)
      `S_BAN: begin
        // [RULE7] power-up banner first
        startSend(`M_BAN, `M_BAN, 1'b0, `S_IDLE);
      end
      `S_SEND: begin
        // one character per cycle while the fifo has room
        if (fifoInReady) begin
          idx_next = idx_reg + 6'h01;
          if (rom[8]) begin
            idx_next = 6'h00;
            if (has2_reg) begin
              msg_next  = msg2_reg;
              has2_next = 1'b0;
            end else begin
              state_next = ret_reg;
            end
          end
        end
      end
      `S_IDLE: begin
        if (take) begin
          char_next = rxData;
          case (rxData)
            // [RULE1] record request queued
            `CH_T: tSet = 1'b1;
            // [RULE8] echo then interval digits
            `CH_L: startSend(`M_ECHO, `M_NUM, 1'b1, `S_IDLE);
            // [RULE19] echo then on or off
            `CH_A: startSend(`M_ECHO, `M_ONOFF, 1'b1, `S_IDLE);
            `CH_SL: startSend(`M_CHR, `M_CHR, 1'b0, `S_SLASH);
            default: state_next = `S_IDLE;
          endcase
        end else if ((tPend_reg || sPend_reg) && !fifoBusy) begin
          // [RULE24] records wait for a silent line
          recReq_next = 1'b1;
          state_next  = `S_WREC;
          // [RULE6] demand requests served first
          if (tPend_reg)
            tServe = 1'b1;
          else
            sServe = 1'b1;
        end
      end
      `S_SLASH: begin
        if (take) begin
          char_next = rxData;
          case (rxData)
            `CH_L: begin
              // [RULE11] echo, prompt, then digit entry
              editVal_next = `IVL_RST;
              editCnt_next = 3'h0;
              startSend(`M_ECHO, `M_PRM, 1'b1, `S_EDIT);
            end
            `CH_A: begin
              // [RULE20] toggle and report new state
              autoClr_next = ~autoClr;
              startSend(`M_ECHO, `M_ONOFF, 1'b1, `S_IDLE);
            end
            // [RULE15] echo and confirmation prompt
            `CH_R: startSend(`M_ECHO, `M_RPR, 1'b1, `S_RWAIT);
            default: startSend(`M_CRLF, `M_CRLF, 1'b0, `S_IDLE);
          endcase
        end
      end
      `S_EDIT: begin
        if (take) begin
          char_next = rxData;
          if (rxData >= `CH_0 && rxData <= `CH_9) begin
            // [RULE11] at most four digits taken
            if (editCnt_reg < `DIG_MAX) begin
              editVal_next = prod[13:0] + {6'h00, rxData - `CH_0};
              editCnt_next = editCnt_reg + 3'h1;
              startSend(`M_CHR, `M_CHR, 1'b0, `S_EDIT);
            end
          end else if (rxData == `CH_BS || rxData == `CH_DEL) begin
            // [RULE12] backspace drops last digit
            if (editCnt_reg != 3'h0) begin
              editVal_next = editVal_reg / 14'd10;
              editCnt_next = editCnt_reg - 3'h1;
              startSend(`M_CHR, `M_CHR, 1'b0, `S_EDIT);
            end
          end else if (rxData == `CH_CR) begin
            // [RULE13] empty entry commits zero
            ivl_next = editVal_reg;
            commit   = 1'b1;
            startSend(`M_CRLF, `M_CRLF, 1'b0, `S_IDLE);
          end else if (rxData == `CH_ESC) begin
            // [RULE12] escape keeps old interval
            startSend(`M_CRLF, `M_CRLF, 1'b0, `S_IDLE);
          end
        end
      end
      `S_RWAIT: begin
        // [RULE15] single reply character, echoed
        if (take) begin
          char_next = rxData;
          startSend(`M_CHR, `M_CHR, 1'b0, `S_RDEC);
        end
      end
      `S_RDEC: begin
        if (char_reg == `CH_Y) begin
          // [RULE16] clear and confirm
          cmdClr = 1'b1;
          startSend(`M_RDN, `M_RDN, 1'b0, `S_IDLE);
        end else begin
          // [RULE17] abandon, total untouched
          startSend(`M_CRLF, `M_CRLF, 1'b0, `S_IDLE);
        end
      end
      `S_WREC: begin
        // the formatter owns the line until it reports done
        if (recordDone)
          state_next = `S_IDLE;
      end
      default: state_next = `S_IDLE;
    endcase
  end

  // [RULE3] due when count reaches interval
  wire sSet = secTick && (interval != `IVL_RST) && !commit &&
              ({1'b0, secCnt_reg} + 15'h0001 >= {1'b0, interval});

  // [RULE22] local minute, signed offset
  wire [11:0] utcMin = {7'h00, rtcHour} * 12'd60 + {6'h00, rtcMin};
  wire [11:0] offMin = {8'h00, zoneHour} * 12'd60 + {6'h00, zoneMin};
  wire [11:0] rawMin = zoneNeg ? (utcMin + `DAY_MIN - offMin)
                               : (utcMin + offMin);
  wire [11:0] locMin = (rawMin >= `DAY_MIN) ? (rawMin - `DAY_MIN)
                                            : rawMin;
  wire        isMid  = (locMin == 12'h000);
  // [RULE18] clear on entering local midnight
  wire        midClr = autoClr && isMid && !midPrev_reg;
  wire [31:0] addAmt = precipValid ? {16'h0000, precipInc} : 32'h0;

  // interpreter and control registers
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg   <= `S_BAN;
      msg_reg     <= `M_BAN;
      msg2_reg    <= `M_BAN;
      has2_reg    <= 1'b0;
      ret_reg     <= `S_IDLE;
      idx_reg     <= 6'h00;
      char_reg    <= 8'h00;
      interval    <= `IVL_RST;
      editVal_reg <= `IVL_RST;
      editCnt_reg <= 3'h0;
      autoClr     <= 1'b0;
      tPend_reg   <= 1'b0;
      sPend_reg   <= 1'b0;
      recordReq   <= 1'b0;
      rxReady     <= 1'b0;
      secCnt_reg  <= `IVL_RST;
      midPrev_reg <= 1'b0;
      total       <= 32'h0;
    end else begin
      state_reg   <= state_next;
      msg_reg     <= msg_next;
      msg2_reg    <= msg2_next;
      has2_reg    <= has2_next;
      ret_reg     <= ret_next;
      idx_reg     <= idx_next;
      char_reg    <= char_next;
      // [RULE2] at most four digits keeps 9999
      interval    <= ivl_next;
      editVal_reg <= editVal_next;
      editCnt_reg <= editCnt_next;
      autoClr     <= autoClr_next;
      recordReq   <= recReq_next;
      rxReady     <= accepts(state_next);
      midPrev_reg <= isMid;
      // a new request wins over the serve of an older one
      tPend_reg   <= tSet || (tPend_reg && !tServe);
      sPend_reg   <= sSet || (sPend_reg && !sServe);
      // [RULE23] commit restarts the schedule
      if (commit)
        secCnt_reg <= `IVL_RST;
      // [RULE4] zero interval keeps the counter at zero
      else if (interval == `IVL_RST)
        secCnt_reg <= `IVL_RST;
      // [RULE5] one second tick per step
      else if (secTick)
        secCnt_reg <= sSet ? `IVL_RST : secCnt_reg + 14'h0001;
      // [RULE14] accumulate until cleared; a clear keeps same-cycle rain
      if (cmdClr || midClr)
        total <= addAmt;
      else
        total <= total + addAmt;
    end
  end
endmodule // serial_record_ctrl
`default_nettype wire

// file: serial_record_ctrl_checker.sv
// port assertions for the serial command interpreter
// assumes one clock domain and an asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module serial_record_ctrl_checker (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic [7:0]  rxData,
  input wire logic        rxValid,
  input wire logic        rxReady,
  input wire logic [7:0]  txData,
  input wire logic        txValid,
  input wire logic        txReady,
  input wire logic        recordReq,
  input wire logic [15:0] precipInc,
  input wire logic        precipValid,
  input wire logic [13:0] interval,
  input wire logic        autoClr,
  input wire logic [31:0] total
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] lastByte; // last byte taken from the host
  logic [5:0] age;      // cycles since it was taken, saturating
  // remember the latest accepted byte so settings can be traced to it
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lastByte <= 8'h00;
      age      <= 6'h3F;
    end else if (rxValid && rxReady) begin
      lastByte <= rxData;
      age      <= 6'h00;
    end else if (age != 6'h3F) begin
      age <= age + 6'h01;
    end
  end
  sequence s_req;
    recordReq;
  endsequence
  // the link stays silent while a record goes out
  sequence s_quiet;
    !rxReady && !txValid;
  endsequence
  property p_rec_pulse;
    s_req |=> !recordReq;
  endproperty
  property p_rec_quiet;
    s_req |-> s_quiet ##1 s_quiet;
  endproperty
  property p_ivl_max;
    interval <= 14'h270F;
  endproperty
  property p_tx_hold;
    txValid && !txReady |=> txValid && $stable(txData);
  endproperty
  property p_add;
    precipValid |=> total == $past(total) + $past(precipInc)
      || total == $past(precipInc);
  endproperty
  property p_clr;
    total < $past(total) |-> (autoClr || lastByte == 8'h59)
      && (total == 32'h0 || total == $past(precipInc));
  endproperty
  property p_ivl_chg;
    $changed(interval) |-> lastByte == 8'h0D && age < 6'h08;
  endproperty
  property p_auto_chg;
    $changed(autoClr) |-> lastByte == 8'h41 && age < 6'h08;
  endproperty
  a_rec_pulse: assert property (p_rec_pulse)
    else $error("record request wider than one cycle");
  a_rec_quiet: assert property (p_rec_quiet)
    else $error("record issued while link busy");
  a_ivl_max: assert property (p_ivl_max)
    else $error("interval above range");
  a_tx_hold: assert property (p_tx_hold)
    else $error("transmit byte dropped or changed");
  a_add: assert property (p_add)
    else $error("increment not added to total");
  a_clr: assert property (p_clr)
    else $error("total lowered without a clear");
  a_ivl_chg: assert property (p_ivl_chg)
    else $error("interval changed without enter");
  a_auto_chg: assert property (p_auto_chg)
    else $error("auto clear changed without toggle");
endmodule // serial_record_ctrl_checker
bind serial_record_ctrl serial_record_ctrl_checker serial_record_ctrl_checker_i (
  .sys_clk(sys_clk), .rst_n(rst_n), .rxData(rxData), .rxValid(rxValid),
  .rxReady(rxReady), .txData(txData), .txValid(txValid),
  .txReady(txReady), .recordReq(recordReq), .precipInc(precipInc),
  .precipValid(precipValid), .interval(interval), .autoClr(autoClr),
  .total(total));
`default_nettype wire

// file: host_model.sv
// host terminal and record formatter facing the command interpreter
// assumes byte valid/ready links on sys_clk, driven at the falling edge
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       sys_clk,
  input  wire logic       slow,      // high: take bytes every other cycle
  output var  logic [7:0] rxData,    // byte to the device
  output var  logic       rxValid,
  input  wire logic       rxReady,
  input  wire logic [7:0] txData,    // byte from the device
  input  wire logic       txValid,
  output var  logic       txReady,
  input  wire logic       recordReq, // record start pulse
  output var  logic       recordDone
);
  logic [7:0] got[$]; // bytes received from the device
  int         recCount; // records requested so far
  int         recWait;  // cycles left in the current record
  initial begin
    rxData     = 8'h00;
    rxValid    = 1'b0;
    txReady    = 1'b0;
    recordDone = 1'b0;
    recCount   = 0;
    recWait    = 0;
  end
  // collect device bytes; a slow host halves its acceptance rate
  always @(posedge sys_clk) if (txValid && txReady) got.push_back(txData);
  always @(negedge sys_clk) txReady <= slow ? ~txReady : 1'b1;
  // record formatter finishes three cycles after each request
  always @(negedge sys_clk) begin
    recordDone <= (recWait == 1);
    if (recWait > 0) recWait = recWait - 1;
    if (recordReq) begin
      recCount = recCount + 1;
      recWait  = 3;
    end
  end
  // hold the byte until taken, then scramble the idle data lines
  task automatic send(input logic [7:0] b);
    @(negedge sys_clk);
    rxData  = b;
    rxValid = 1'b1;
    do @(posedge sys_clk); while (rxReady !== 1'b1);
    @(negedge sys_clk);
    rxValid = 1'b0;
    rxData  = ~b;
  endtask
  // next byte from the device, unknown if none comes in time
  task automatic pop(output logic [7:0] b);
    int n;
    n = 0;
    while (got.size() == 0 && n < 400) begin
      @(posedge sys_clk);
      n++;
    end
    b = (got.size() > 0) ? got.pop_front() : 8'hXX;
  endtask
endmodule // host_model
`default_nettype wire

// file: tb_serial_record_output_and_total_control.sv
// self-checking bench for the serial command interpreter
// assumes the host model file and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_serial_record_output_and_total_control;
  logic sys_clk, rst_n, slow, secTick, precipValid, zoneNeg;
  logic rxValid, rxReady, txValid, txReady, recordReq, recordDone, autoClr;
  logic [7:0]  rxData, txData;
  logic [15:0] precipInc;
  logic [4:0]  rtcHour;
  logic [5:0]  rtcMin, zoneMin;
  logic [3:0]  zoneHour;
  logic [13:0] interval;
  logic [31:0] total;
  int mismatches, cmp_count;
  string prm = "/L SSSS\015\n"; // interval edit prompt
  serial_record_ctrl serial_record_ctrl_i (.sys_clk(sys_clk),
    .rst_n(rst_n), .rxData(rxData), .rxValid(rxValid), .rxReady(rxReady),
    .txData(txData), .txValid(txValid), .txReady(txReady),
    .secTick(secTick), .recordReq(recordReq), .recordDone(recordDone),
    .precipInc(precipInc), .precipValid(precipValid), .rtcHour(rtcHour),
    .rtcMin(rtcMin), .zoneNeg(zoneNeg), .zoneHour(zoneHour),
    .zoneMin(zoneMin), .interval(interval), .autoClr(autoClr),
    .total(total));
  host_model host_model_i (.sys_clk(sys_clk), .slow(slow),
    .rxData(rxData), .rxValid(rxValid), .rxReady(rxReady),
    .txData(txData), .txValid(txValid), .txReady(txReady),
    .recordReq(recordReq), .recordDone(recordDone));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task cmp32(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task cmp8(input logic [7:0] g, input logic [7:0] e);
    cmp32({24'h0, g}, {24'h0, e});
  endtask
  task summarize;
    $display("mismatches=%0d cmp_count=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // host helpers: send text, expect text, one second, one increment
  task cmd(input string s);
    for (int i = 0; i < s.len(); i++) host_model_i.send(s[i]);
  endtask
  task expect_str(input string s);
    logic [7:0] b;
    for (int i = 0; i < s.len(); i++) begin
      host_model_i.pop(b);
      cmp8(b, s[i]);
    end
  endtask
  task tick;
    @(negedge sys_clk) secTick = 1'b1;
    @(negedge sys_clk) secTick = 1'b0;
    repeat (30) @(negedge sys_clk);
  endtask
  task add(input logic [15:0] v);
    @(negedge sys_clk) precipInc = v;
    precipValid = 1'b1;
    @(negedge sys_clk) precipValid = 1'b0;
  endtask
  task setl(input string d);
    cmd({"/L", d, "\015"});
    expect_str({prm, d, "\015\n"});
  endtask
  task recs(input int n);
    cmp32(host_model_i.recCount, n);
  endtask
  // banner is sent with the host taking a byte only every other cycle, so the fifo fills up
  task t_banner;
    int lf;
    logic [7:0] b;
    lf = 0;
    repeat (30) @(negedge sys_clk);
    cmp8({7'h0, rxReady}, 8'h00);
    for (int i = 0; i < 41; i++) begin
      host_model_i.pop(b);
      if (b === 8'h0A) lf++;
    end
    cmp32(lf, 4);
    slow = 1'b0;
  endtask
  task t_interval;
    cmd("L");
    expect_str("L 0000\015\n");
    cmd("/L12\0103456\015");
    expect_str({prm, "12\010345\015\n"});
    cmp32(interval, 32'h541);
    cmd("L");
    expect_str("L 1345\015\n");
    cmd("/L9\177\033");
    expect_str({prm, "9\177\015\n"});
    cmp32(interval, 32'h541);
    setl("");
    cmp32(interval, 32'h0);
    setl("9999");
    cmp32(interval, 32'h270F);
  endtask
  task t_stream;
    int n;
    n = host_model_i.recCount;
    cmd("T");
    repeat (20) @(negedge sys_clk);
    recs(n + 1);
    cmp32(host_model_i.got.size(), 0);
    setl("1");
    repeat (3) tick();
    recs(n + 4);
    setl("3");
    repeat (2) tick();
    recs(n + 4);
    tick();
    recs(n + 5);
    setl("");
    repeat (4) tick();
    recs(n + 5);
  endtask
  task t_total;
    string q;
    q = "/R Reset precipitation total? (Y/N): ";
    add(16'h0100);
    add(16'h0023);
    cmp32(total, 32'h123);
    cmd("/R");
    expect_str(q);
    repeat (20) @(negedge sys_clk);
    cmp32(host_model_i.got.size(), 0);
    cmd("N");
    expect_str("N\015\n");
    cmp32(total, 32'h123);
    cmd("/RY");
    expect_str({q, "Y\015\nTotal reset to zero.\015\n"});
    cmp32(total, 32'h0);
  endtask
  task t_auto;
    cmd("A");
    expect_str("A Auto Reset is OFF.\015\n");
    cmd("/Q/A");
    expect_str("/\015\n/A Auto Reset is ON.\015\n");
    cmp32(autoClr, 32'h1);
    add(16'h0042);
    @(negedge sys_clk) zoneNeg = 1'b1;
    zoneHour = 4'h5;
    rtcHour = 5'h04;
    rtcMin = 6'h3B;
    repeat (5) @(negedge sys_clk);
    cmp32(total, 32'h42);
    rtcHour = 5'h05;
    rtcMin = 6'h00;
    repeat (5) @(negedge sys_clk);
    cmp32(total, 32'h0);
    cmd("/A");
    expect_str("/A Auto Reset is OFF.\015\n");
    cmp32(autoClr, 32'h0);
  endtask
  // watchdog: 40000 cycles, far beyond the few thousand the tests need
  initial begin
    #400000;
    mismatches++;
    summarize();
  end
  initial begin
    mismatches = 0;
    cmp_count = 0;
    {rst_n, secTick, precipValid, zoneNeg} = 4'h0;
    {precipInc, zoneHour, zoneMin, rtcMin} = 32'h0;
    rtcHour = 5'h0C;
    slow = 1'b1;
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk) rst_n = 1'b1;
    t_banner();
    t_interval();
    t_stream();
    t_total();
    t_auto();
    summarize();
  end
endmodule // tb_serial_record_output_and_total_control
`default_nettype wire
